// *** verilog/scp_device.sv ***
// Device end: serial control port slave with its clock and port registers
`timescale 1ns/1ps
module scp_device
	import scp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	scp_if.dev_mp link,
	input wire logic spdif_transmitter,
	input wire logic spdif_receive_in,
	output logic spdif_transmit_out,
	output logic [1:0] rate_converter_clock_divider,
	output logic [1:0] internal_clock_two_divider,
	output logic [1:0] internal_clock_one_divider,
	output logic [1:0] rate_converter_clock_select,
	output logic spdif_out_source_select,
	output logic [1:0] playback_port_clock_source,
	output logic [2:0] playback_serial_format_select,
	output logic playback_clocks_oe_n,
	output logic playback_format_reserved,
	output logic [1:0] aux_in_port_clock_source,
	output logic [2:0] aux_in_serial_format_select,
	output logic aux_in_clocks_oe_n,
	output logic aux_in_format_reserved
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam int SLOT_CLK = 0;
	localparam int SLOT_SPDIF = 1;
	localparam int SLOT_PBK = 2;
	localparam int SLOT_AUX = 3;

	typedef struct packed {
		logic strb_q;
		logic sck_q;
		logic hdr;
		logic rw;
		logic [2:0] cnt;
		logic [6:0] addr;
		logic [7:0] shin;
		logic [7:0] shout;
		logic sdo;
		logic txo;
		logic [3:0][7:0] regs;
	} scp_dev_st_t;

	scp_dev_st_t s_r;
	scp_dev_st_t s_nxt;
	logic [3:0] pins_s;
	logic strb_s;
	logic sck_s;
	logic sdi_s;
	logic rx_s;
	logic strb_fall;
	logic sck_rise;
	logic sck_fall;
	logic [7:0] din;
	logic [7:0] rd;
	logic [2:0] slot;
	// Last bit of the current byte is on the wire
	logic byte_done;

	// Map an address to {hit, slot}
	function automatic logic [2:0] reg_slot(input logic [6:0] a);
		case (a)
			SCP_OFS_CLKCTL: reg_slot = {1'b1, 2'(SLOT_CLK)};
			SCP_OFS_SPDIF: reg_slot = {1'b1, 2'(SLOT_SPDIF)};
			SCP_OFS_PBK: reg_slot = {1'b1, 2'(SLOT_PBK)};
			SCP_OFS_AUX: reg_slot = {1'b1, 2'(SLOT_AUX)};
			default: reg_slot = 3'h0;
		endcase
	endfunction : reg_slot

	// Block accesses walk upward through the map and wrap at the top
	function automatic logic [6:0] addr_step(input logic [6:0] a);
		addr_step = a + 7'h01;
	endfunction : addr_step

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	scp_sync #(
		.W(4),
		.RST_VAL(4'h3)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({spdif_receive_in, link.control_serial_in, link.control_serial_clock, link.transfer_framing_strobe}),
		.q(pins_s)
	);

	assign strb_s = pins_s[0];
	assign sck_s = pins_s[1];
	assign sdi_s = pins_s[2];
	assign rx_s = pins_s[3];
	assign strb_fall = s_r.strb_q & ~strb_s;
	assign sck_rise = ~s_r.sck_q & sck_s;
	assign sck_fall = s_r.sck_q & ~sck_s;
	assign byte_done = (s_r.cnt == 3'h7);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		din = {s_r.shin[6:0], sdi_s};
		slot = reg_slot(s_r.addr);
		rd = slot[2] ? s_r.regs[slot[1:0]] : 8'h00;
		s_nxt.strb_q = strb_s;
		s_nxt.sck_q = sck_s;
		s_nxt.txo = s_r.regs[SLOT_SPDIF][SCP_SPDIF_OUT_SOURCE_SELECT_BIT] ? rx_s : spdif_transmitter;
		if (strb_s || strb_fall) begin
			s_nxt.hdr = 1'b0;
			s_nxt.cnt = 3'h0;
			s_nxt.sdo = 1'b0;
		end else if (sck_rise) begin
			s_nxt.cnt = s_r.cnt + 3'h1;
			if (!s_r.hdr) begin
				s_nxt.shin = din;
				if (byte_done) begin
					s_nxt.addr = din[7:1];
					s_nxt.rw = din[0];
					s_nxt.hdr = 1'b1;
				end
			end else if (!s_r.rw) begin
				s_nxt.shin = din;
				if (byte_done) begin
					if (slot[2]) begin
						s_nxt.regs[slot[1:0]] = din & scp_wmask(s_r.addr);
					end
					s_nxt.addr = addr_step(s_r.addr);
				end
			end else if (byte_done) begin
				s_nxt.addr = addr_step(s_r.addr);
			end
		end else if (sck_fall && s_r.hdr && s_r.rw) begin
			// Serial input is not looked at here
			if (s_r.cnt == 3'h0) begin
				s_nxt.sdo = rd[7];
				s_nxt.shout = {rd[6:0], 1'b0};
			end else begin
				s_nxt.sdo = s_r.shout[7];
				s_nxt.shout = {s_r.shout[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.strb_q <= 1'b1;
			s_r.sck_q <= 1'b1;
			s_r.regs[SLOT_CLK] <= SCP_RST_CLKCTL;
			s_r.regs[SLOT_SPDIF] <= SCP_RST_SPDIF;
			s_r.regs[SLOT_PBK] <= SCP_RST_PBK;
			s_r.regs[SLOT_AUX] <= SCP_RST_AUX;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.control_serial_out = s_r.sdo;
	assign spdif_transmit_out = s_r.txo;
	assign rate_converter_clock_divider = s_r.regs[SLOT_CLK][SCP_SRCDIV_LSB +: 2];
	assign internal_clock_two_divider = s_r.regs[SLOT_CLK][SCP_CLK2DIV_LSB +: 2];
	assign internal_clock_one_divider = s_r.regs[SLOT_CLK][SCP_CLK1DIV_LSB +: 2];
	assign rate_converter_clock_select = s_r.regs[SLOT_CLK][SCP_MCLKSEL_LSB +: 2];
	assign spdif_out_source_select = s_r.regs[SLOT_SPDIF][SCP_SPDIF_OUT_SOURCE_SELECT_BIT];
	assign playback_port_clock_source = s_r.regs[SLOT_PBK][SCP_CLKSRC_LSB +: 2];
	assign playback_serial_format_select = s_r.regs[SLOT_PBK][SCP_FMT_LSB +: 3];
	assign aux_in_port_clock_source = s_r.regs[SLOT_AUX][SCP_CLKSRC_LSB +: 2];
	assign aux_in_serial_format_select = s_r.regs[SLOT_AUX][SCP_FMT_LSB +: 3];
	assign playback_clocks_oe_n = (playback_port_clock_source == SCP_SRC_SLAVE);
	assign aux_in_clocks_oe_n = (aux_in_port_clock_source == SCP_SRC_SLAVE);
	assign playback_format_reserved = scp_fmt_reserved(playback_serial_format_select);
	assign aux_in_format_reserved = scp_fmt_reserved(aux_in_serial_format_select);
endmodule : scp_device

// *** include/scp_pkg.sv ***
// Shared constants, types and helpers of the serial control port
package scp_pkg;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int SCP_ADDR_W = 7;
	localparam int SCP_DATA_W = 8;
	localparam int SCP_XFER_BITS = 16;
	localparam int SCP_HDR_BITS = 8;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] SCP_OFS_CLKCTL = 7'h00;
	localparam logic [6:0] SCP_OFS_SPDIF = 7'h03;
	localparam logic [6:0] SCP_OFS_PBK = 7'h04;
	localparam logic [6:0] SCP_OFS_AUX = 7'h05;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SCP_SRCDIV_LSB = 6;
	localparam int SCP_CLK2DIV_LSB = 4;
	localparam int SCP_CLK1DIV_LSB = 2;
	localparam int SCP_MCLKSEL_LSB = 0;
	localparam int SCP_SPDIF_OUT_SOURCE_SELECT_BIT = 0;
	localparam int SCP_CLKSRC_LSB = 3;
	localparam int SCP_FMT_LSB = 0;
	// ----------------------------------------------------------------
	// Reset values and writable bits
	// ----------------------------------------------------------------
	localparam logic [7:0] SCP_RST_CLKCTL = 8'h00;
	localparam logic [7:0] SCP_RST_SPDIF = 8'h00;
	localparam logic [7:0] SCP_RST_PBK = 8'h00;
	localparam logic [7:0] SCP_RST_AUX = 8'h00;
	localparam logic [7:0] SCP_WM_CLKCTL = 8'hFF;
	localparam logic [7:0] SCP_WM_SPDIF = 8'h01;
	localparam logic [7:0] SCP_WM_PORT = 8'h1F;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SCP_CLK_PERIOD_NS = 100;
	localparam int SCP_SCLK_HALF_NS = 500;
	localparam int SCP_SCLK_HALF_CYC = (SCP_SCLK_HALF_NS + SCP_CLK_PERIOD_NS - 1) / SCP_CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// Field encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SCP_DIV_1, SCP_DIV_1P5, SCP_DIV_2, SCP_DIV_3} scp_div_t;
	typedef enum logic [1:0] {SCP_MCLK_INTERNAL_CLOCK_ONE, SCP_MCLK_INTERNAL_CLOCK_TWO, SCP_MCLK_PLL512, SCP_MCLK_PLL256} scp_mclk_t;
	typedef enum logic [1:0] {SCP_SRC_SLAVE, SCP_SRC_PLL, SCP_SRC_INTERNAL_CLOCK_ONE, SCP_SRC_INTERNAL_CLOCK_TWO} scp_clksrc_t;
	localparam logic [2:0] SCP_FMT_LJ = 3'h0;
	localparam logic [2:0] SCP_FMT_I2S = 3'h1;
	localparam logic [2:0] SCP_FMT_RJ24 = 3'h4;
	localparam logic [2:0] SCP_FMT_RJ16 = 3'h7;

	// Bits that may hold a one; all others are reserved
	function automatic logic [7:0] scp_wmask(input logic [6:0] a);
		case (a)
			SCP_OFS_CLKCTL: scp_wmask = SCP_WM_CLKCTL;
			SCP_OFS_SPDIF: scp_wmask = SCP_WM_SPDIF;
			SCP_OFS_PBK, SCP_OFS_AUX: scp_wmask = SCP_WM_PORT;
			default: scp_wmask = 8'h00;
		endcase
	endfunction : scp_wmask

	// Format codes 010 and 011 are undefined
	function automatic logic scp_fmt_reserved(input logic [2:0] f);
		scp_fmt_reserved = (f[2:1] == 2'b01);
	endfunction : scp_fmt_reserved
endpackage : scp_pkg

// *** include/scp_if.sv ***
// Four-wire serial control link between host and device
`timescale 1ns/1ps
interface scp_if;
	logic control_serial_clock;
	logic transfer_framing_strobe;
	logic control_serial_in;
	logic control_serial_out;

	modport host_mp (
		output control_serial_clock,
		output transfer_framing_strobe,
		output control_serial_in,
		input control_serial_out
	);
	modport dev_mp (
		input control_serial_clock,
		input transfer_framing_strobe,
		input control_serial_in,
		output control_serial_out
	);
endinterface : scp_if

// *** verilog/scp_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module scp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} scp_sync_st_t;

	scp_sync_st_t s_r;
	scp_sync_st_t s_nxt;

	always_comb begin
		s_nxt.meta = d;
		s_nxt.q = s_r.meta;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= {RST_VAL, RST_VAL};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule : scp_sync

// *** verilog/scp_host.sv ***
// Host end: serial control port master that frames single and block accesses
`timescale 1ns/1ps
module scp_host
	import scp_pkg::*;
#(
	parameter int SCLK_HALF = SCP_SCLK_HALF_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	scp_if.host_mp link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [6:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic req_more,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic busy
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_WAIT, H_END, H_GAP} scp_hst_t;

	typedef struct packed {
		scp_hst_t st;
		logic [7:0] tmr;
		logic [4:0] bitn;
		logic [15:0] sho;
		logic [7:0] shi;
		logic rw;
		logic [6:0] addr;
		logic more;
		logic sck;
		logic strb;
		logic sdi;
		logic rsp;
		logic [7:0] rdata;
	} scp_host_st_t;

	localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);

	scp_host_st_t s_r;
	scp_host_st_t s_nxt;
	logic sdo_s;
	logic [7:0] din;
	logic tdone;
	logic [7:0] nwd;

	scp_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(link.control_serial_out),
		.q(sdo_s)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign tdone = (s_r.tmr == 8'h00);
	assign din = {s_r.shi[6:0], sdo_s};
	assign req_ready = (s_r.st == H_IDLE) || (s_r.st == H_WAIT);
	// Next block byte: zeros for reads, reserved bits of the next register cleared for writes
	assign nwd = s_r.rw ? 8'h00 : (req_wdata & scp_wmask(s_r.addr + 7'h01));

	always_comb begin
		s_nxt = s_r;
		s_nxt.rsp = 1'b0;
		if (!tdone) begin
			s_nxt.tmr = s_r.tmr - 8'h01;
		end
		case (s_r.st)
			H_IDLE: begin
				if (req_valid) begin
					// Reads send zeros, reserved bits always zero
					s_nxt.sho = {req_addr, ~req_write,
						req_write ? (req_wdata & scp_wmask(req_addr)) : 8'h00};
					s_nxt.bitn = 5'(SCP_XFER_BITS);
					s_nxt.rw = ~req_write;
					s_nxt.addr = req_addr;
					s_nxt.more = req_more;
					s_nxt.strb = 1'b0;
					s_nxt.tmr = HALF_M1;
					s_nxt.st = H_LEAD;
				end
			end
			H_LEAD, H_LOW: begin
				if (s_r.st == H_LOW && tdone) begin
					s_nxt.sck = 1'b1;
					s_nxt.tmr = HALF_M1;
					s_nxt.st = H_HIGH;
				end else if (s_r.st == H_LEAD && tdone) begin
					s_nxt.sck = 1'b0;
					s_nxt.sdi = s_r.sho[15];
					s_nxt.sho = {s_r.sho[14:0], 1'b0};
					s_nxt.tmr = HALF_M1;
					s_nxt.st = H_LOW;
				end
			end
			H_HIGH: begin
				if (tdone) begin
					s_nxt.shi = din;
					s_nxt.bitn = s_r.bitn - 5'h01;
					s_nxt.tmr = HALF_M1;
					if (s_r.bitn == 5'h01) begin
						s_nxt.rsp = s_r.rw;
						s_nxt.rdata = din;
						s_nxt.st = s_r.more ? H_WAIT : H_END;
					end else begin
						s_nxt.sck = 1'b0;
						s_nxt.sdi = s_r.sho[15];
						s_nxt.sho = {s_r.sho[14:0], 1'b0};
						s_nxt.st = H_LOW;
					end
				end
			end
			H_WAIT: begin
				if (req_valid) begin
					s_nxt.addr = s_r.addr + 7'h01;
					s_nxt.bitn = 5'(SCP_DATA_W);
					s_nxt.more = req_more;
					s_nxt.sck = 1'b0;
					s_nxt.sdi = nwd[7];
					s_nxt.sho = {nwd[6:0], 9'h000};
					s_nxt.tmr = HALF_M1;
					s_nxt.st = H_LOW;
				end
			end
			H_END: begin
				if (tdone) begin
					s_nxt.strb = 1'b1;
					s_nxt.sdi = 1'b0;
					s_nxt.tmr = HALF_M1;
					s_nxt.st = H_GAP;
				end
			end
			H_GAP: begin
				if (tdone) begin
					s_nxt.st = H_IDLE;
				end
			end
			default: begin
				s_nxt.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.st <= H_IDLE;
			s_r.sck <= 1'b1;
			s_r.strb <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.control_serial_clock = s_r.sck;
	assign link.transfer_framing_strobe = s_r.strb;
	assign link.control_serial_in = s_r.sdi;
	assign rsp_valid = s_r.rsp;
	assign rsp_rdata = s_r.rdata;
	assign busy = (s_r.st != H_IDLE);
endmodule : scp_host

// *** testbench/scp_assertions.sv ***
// Checker of framing and timing on the serial control link
`timescale 1ns/1ps
module scp_assertions (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic control_serial_clock,
	input wire logic transfer_framing_strobe,
	input wire logic control_serial_in,
	input wire logic control_serial_out
);
	wire sck = control_serial_clock;
	wire cs = transfer_framing_strobe;
	wire sdi = control_serial_in;
	wire sdo = control_serial_out;
	logic sck_r;
	logic [7:0] falls_r;
	// ------------------------------------------
	// Clock falls counted within one frame
	// ------------------------------------------
	always_ff @(posedge clk) begin
		sck_r <= sck;
		if (sys_rst || cs) begin
			falls_r <= 8'h00;
		end else if (sck_r && !sck) begin
			falls_r <= falls_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_idle_clock_high: assert property (cs |-> sck)
		else $error("clock low outside frame");
	a_frame_lead: assert property ($fell(cs) |-> sck [*5] ##1 !sck)
		else $error("bad lead after strobe fall");
	a_low_half: assert property ($fell(sck) |-> !sck [*5] ##1 sck)
		else $error("bad low half");
	a_high_half: assert property ($rose(sck) && !cs |-> sck [*5])
		else $error("short high half");
	a_data_steady: assert property ($rose(sck) |-> $stable(sdi) ##1 $stable(sdi))
		else $error("data moved at sampling edge");
	a_whole_bytes: assert property ($rose(cs) |-> falls_r >= 8'h10 && falls_r[2:0] == 3'h0)
		else $error("frame not whole bytes");
	a_out_quiet: assert property (cs [*5] |-> !sdo)
		else $error("output active outside frame");
	a_out_on_low: assert property ($changed(sdo) |-> !sck || cs)
		else $error("output moved while clock high");
endmodule : scp_assertions

// *** testbench/tb_serial_control_port_regs.sv ***
// Bench joining host and device ends, with a raw driver on a second link
`timescale 1ns/1ps
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_serial_control_port_regs;
	import scp_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [6:0] req_addr = 7'h00;
	logic [7:0] req_wdata = 8'h00;
	logic req_more = 1'b0;
	logic tx = 1'b0;
	logic rx = 1'b0;
	logic req_ready, rsp_valid, busy, txo, sel, poe_n, pres, aoe_n, ares;
	logic [7:0] rsp_rdata, q, pb, ax;
	logic [1:0] rcd, c2d, c1d, rcs, pcs, acs;
	logic [2:0] pfmt, afmt;
	logic [15:0] mon;
	logic [1:0] mon_prev = 2'b11;
	logic [6:0] ofs [4] = '{SCP_OFS_CLKCTL, SCP_OFS_SPDIF, SCP_OFS_PBK, SCP_OFS_AUX};
	int mon_n = 0;
	int errors = 0;
	int comparisons = 0;
	scp_if i_scp_if();
	scp_if i_scp_if_b();
	always #50 clk = ~clk;
	scp_host #(.SCLK_HALF(5)) i_scp_host (.clk, .sys_rst, .link(i_scp_if.host_mp), .req_valid, .req_ready,
		.req_write, .req_addr, .req_wdata, .req_more, .rsp_valid, .rsp_rdata, .busy);
	scp_device i_scp_device (.clk, .sys_rst, .link(i_scp_if.dev_mp), .spdif_transmitter(tx), .spdif_receive_in(rx),
		.spdif_transmit_out(txo), .rate_converter_clock_divider(rcd), .internal_clock_two_divider(c2d),
		.internal_clock_one_divider(c1d), .rate_converter_clock_select(rcs), .spdif_out_source_select(sel),
		.playback_port_clock_source(pcs), .playback_serial_format_select(pfmt), .playback_clocks_oe_n(poe_n),
		.playback_format_reserved(pres), .aux_in_port_clock_source(acs), .aux_in_serial_format_select(afmt),
		.aux_in_clocks_oe_n(aoe_n), .aux_in_format_reserved(ares));
	scp_device i_scp_device_b (.clk, .sys_rst, .link(i_scp_if_b.dev_mp), .spdif_transmitter(1'b0),
		.spdif_receive_in(1'b0), .spdif_transmit_out(), .rate_converter_clock_divider(),
		.internal_clock_two_divider(), .internal_clock_one_divider(), .rate_converter_clock_select(),
		.spdif_out_source_select(), .playback_port_clock_source(), .playback_serial_format_select(),
		.playback_clocks_oe_n(), .playback_format_reserved(), .aux_in_port_clock_source(),
		.aux_in_serial_format_select(), .aux_in_clocks_oe_n(), .aux_in_format_reserved());
	scp_assertions i_scp_assertions (.clk, .sys_rst, .control_serial_clock(i_scp_if.control_serial_clock),
		.transfer_framing_strobe(i_scp_if.transfer_framing_strobe), .control_serial_in(i_scp_if.control_serial_in),
		.control_serial_out(i_scp_if.control_serial_out));
	// ------------------------------------------
	// Wire monitor: bits seen at rising clock since strobe fall
	// ------------------------------------------
	always @(posedge clk) begin
		mon_prev <= {i_scp_if.transfer_framing_strobe, i_scp_if.control_serial_clock};
		if (mon_prev[1] && !i_scp_if.transfer_framing_strobe) begin
			mon_n <= 0;
		end else if (!mon_prev[0] && i_scp_if.control_serial_clock) begin
			mon <= {mon[14:0], i_scp_if.control_serial_in};
			mon_n <= mon_n + 1;
		end
	end
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d, input logic m, output logic [7:0] r);
		int n;
		n = 0;
		r = 8'h00;
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_more <= m;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 4000);
		@(posedge clk);
		req_valid <= 1'b0;
		if (!w) begin
			do begin
				@(negedge clk);
				n++;
			end while (rsp_valid !== 1'b1 && n < 4000);
			r = rsp_rdata;
		end
		@(posedge clk);
		if (n >= 4000) begin
			errors++;
			$display("[FAIL] %0t access timed out", $time);
		end
	endtask : access
	task automatic settle();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy !== 1'b0 && n < 4000);
		if (n >= 4000) begin
			errors++;
			$display("[FAIL] %0t settle timed out", $time);
		end
		@(posedge clk);
	endtask : settle
	// Bit-banged frame on the second link, half period of five cycles
	task automatic raw(input logic [15:0] v, input int nb, output logic [7:0] r);
		i_scp_if_b.transfer_framing_strobe <= 1'b0;
		repeat (5) @(posedge clk);
		for (int i = 15; i > 15 - nb; i--) begin
			i_scp_if_b.control_serial_clock <= 1'b0;
			i_scp_if_b.control_serial_in <= v[i];
			repeat (5) @(posedge clk);
			i_scp_if_b.control_serial_clock <= 1'b1;
			repeat (4) @(posedge clk);
			@(negedge clk);
			r = {r[6:0], i_scp_if_b.control_serial_out};
			@(posedge clk);
		end
		i_scp_if_b.transfer_framing_strobe <= 1'b1;
		i_scp_if_b.control_serial_in <= ~v[16 - nb];
		repeat (10) @(posedge clk);
	endtask : raw
	initial begin
		#3_000_000;
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end
	initial begin
		i_scp_if_b.control_serial_clock = 1'b1;
		i_scp_if_b.transfer_framing_strobe = 1'b1;
		i_scp_if_b.control_serial_in = 1'b0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		`CK({poe_n, aoe_n, pres, ares, sel, rcd, c2d, c1d, rcs, pcs, pfmt, acs, afmt}, 23'h60_0000)
		`CK({i_scp_if.control_serial_clock, i_scp_if.transfer_framing_strobe}, 2'b11)
		for (int i = 0; i < 4; i++) begin
			access(1'b0, ofs[i], 8'h00, 1'b0, q);
			`CK(q, 8'h00)
		end
		settle();
		`CK({mon_n[4:0], mon}, {5'h10, SCP_OFS_AUX, 1'b1, 8'h00})
		$display("test reset_values done");
		for (int i = 0; i < 4; i++) begin
			pb = {4{i[1:0]}};
			access(1'b1, SCP_OFS_CLKCTL, pb, 1'b0, q);
			settle();
			`CK({mon_n[4:0], mon}, {5'h10, SCP_OFS_CLKCTL, 1'b0, pb})
			`CK({rcd, c2d, c1d, rcs}, pb)
			access(1'b0, SCP_OFS_CLKCTL, 8'h00, 1'b0, q);
			`CK(q, pb)
		end
		$display("test clock_fields done");
		for (int m = 1; m >= 0; m--) begin
			access(1'b1, SCP_OFS_SPDIF, {8{m[0]}}, 1'b0, q);
			access(1'b0, SCP_OFS_SPDIF, 8'h00, 1'b0, q);
			`CK({sel, q}, {m[0], 7'h00, m[0]})
			for (int i = 0; i < 4; i++) begin
				tx <= i[0];
				rx <= i[1];
				repeat (4) @(negedge clk);
				`CK(txo, m[0] ? i[1] : i[0])
				@(posedge clk);
			end
		end
		$display("test spdif_source done");
		for (int j = 0; j < 8; j++) begin
			pb = {3'b000, j[1:0], j[2:0]};
			ax = {3'b000, ~j[1:0], ~j[2:0]};
			access(1'b1, SCP_OFS_PBK, pb, 1'b1, q);
			access(1'b1, SCP_OFS_CLKCTL, ax, 1'b0, q);
			settle();
			`CK({mon_n[4:0], mon}, {5'h18, pb, ax})
			`CK({pcs, pfmt, poe_n, pres}, {j[1:0], j[2:0], j[1:0] == 2'b00, j[2:1] == 2'b01})
			`CK({acs, afmt, aoe_n, ares}, {~j[1:0], ~j[2:0], ~j[1:0] == 2'b00, ~j[2:1] == 2'b01})
			access(1'b0, SCP_OFS_SPDIF, 8'h00, 1'b1, q);
			`CK(q, 8'h00)
			access(1'b0, SCP_OFS_SPDIF, 8'h00, 1'b1, q);
			`CK(q, pb)
			access(1'b0, SCP_OFS_SPDIF, 8'h00, 1'b0, q);
			`CK(q, ax)
		end
		$display("test port_blocks done");
		raw({SCP_OFS_PBK, 1'b0, 8'hFF}, 16, q);
		raw({SCP_OFS_PBK, 1'b1, 8'h00}, 16, q);
		`CK(q, SCP_WM_PORT)
		raw({SCP_OFS_PBK, 1'b1, 8'hA5}, 16, q);
		`CK(q, SCP_WM_PORT)
		raw({SCP_OFS_PBK, 1'b0, 8'h00}, 12, q);
		raw({SCP_OFS_PBK, 1'b1, 8'h00}, 16, q);
		`CK(q, SCP_WM_PORT)
		raw({7'h02, 1'b0, 8'hAA}, 16, q);
		raw({7'h02, 1'b1, 8'hFF}, 16, q);
		`CK(q, 8'h00)
		$display("test raw_link done");
		conclude();
	end
endmodule : tb_serial_control_port_regs
